// ---- bench/tb_timer_mode_and_irq_control.sv ----
// Self-checking bench for the timer mode and interrupt control block
module tb_timer_mode_and_irq_control;
  timeunit 1ns;
  timeprecision 1ps;
  import tmic_pkg::*;
  logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize, pwm_irq_lvl, cap_irq_lvl;
  logic trig_pin, meas_pin, pwm_out, irq, pwm_irq_fwd, cap_irq_fwd;
  int errors, total_checks, cyc, n, d;
  assign hready = hreadyout;

  tmic_timer_ctrl tmic_timer_ctrl_inst (.core_clk(core_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pwm_timer_input_pin(trig_pin), .capture_input_pin(meas_pin),
    .pwm_out(pwm_out), .irq(irq), .pwm_irq_fwd(pwm_irq_fwd),
    .pwm_irq_lvl(pwm_irq_lvl), .cap_irq_fwd(cap_irq_fwd),
    .cap_irq_lvl(cap_irq_lvl));
  tmic_pin_model tmic_pin_model_inst (.core_clk(core_clk),
    .trig_pin(trig_pin), .meas_pin(meas_pin));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // Hang guard, well above the longest sequence
  always @(posedge core_clk) begin
    cyc++;
    if (cyc >= 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // Tolerance covers prescaler phase and pin synchroniser delay
  task automatic near(input logic [31:0] got, input int e, input int t);
    total_checks++;
    if ($isunknown(got) || int'(got) > e + t || int'(got) < e - t) begin
      errors++;
      $display("CHECK FAILED %0t: got %0d near %0d", $time, got, e);
    end
  endtask : near

  task automatic xfer(input logic [7:0] a, input bit w,
                      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0000_0000, q);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask : rdchk

  task automatic pwm_cfg(input logic [7:0] m, input logic [31:0] w);
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_PWM_MODE, {24'h00_0000, m});
    wr(OFS_PWM_RELOAD, w);
    wr(OFS_START, 32'h0000_0001);
  endtask : pwm_cfg

  task automatic hi_time(output int h);
    int k;
    k = 0;
    h = 0;
    while (pwm_out !== 1'b1 && k < 100) begin
      @(posedge core_clk);
      k++;
    end
    while (pwm_out === 1'b1 && h < 3000) begin
      @(posedge core_clk);
      h++;
    end
  endtask : hi_time

  initial begin
    errors = 0;
    total_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rdchk(OFS_PWM_ICR, 32'h0000_0000);
    rdchk(OFS_CAP_ICR, 32'h0000_0000);
    // Zero wait states, always OKAY
    chk({hreadyout, hresp}, 32'h0000_0002);
    wr(OFS_PWM_ICR, 32'h0000_00FF);
    rdchk(OFS_PWM_ICR, 32'h0000_000F);
    chk({pwm_irq_fwd, pwm_irq_lvl}, 32'h0000_000F);
    for (int l = 0; l < 8; l++) begin
      wr(OFS_CAP_ICR, 32'h0000_0008 | l);
      repeat (2) @(posedge core_clk);
      chk({cap_irq_fwd, cap_irq_lvl}, (l == 0) ? 0 : 8 | l);
    end
    wr(OFS_PWM_ICR, 32'h0000_0000);
    wr(OFS_CAP_ICR, 32'h0000_0000);
    wr(OFS_CAP_MODE, 32'h0000_00FF);
    rdchk(OFS_CAP_MODE, 32'h0000_00CF);
    wr(OFS_PWM_MODE, 32'h0000_00FF);
    rdchk(OFS_PWM_MODE, 32'h0000_00FF);
    wr(8'h3C, 32'h0000_00FF);
    rdchk(8'h3C, 32'h0000_0000);
    // Count start bit clear: no output even when triggered
    pwm_cfg(8'h27, 32'h0000_0004);
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_TRIG, 32'h0000_0001);
    hi_time(n);
    chk(n, 0);
    // Prescaler phase is unknown, so allow one tick of slack
    for (int s = 0; s < 4; s++) begin
      d = (s == 0) ? 2 : (s == 1) ? 16 : (s == 2) ? 64 : 512;
      pwm_cfg({s[1:0], 6'h27}, 32'h0000_0104);
      wr(OFS_TRIG, 32'h0000_0001);
      hi_time(n);
      near(n, 4 * d, d);
    end
    pwm_cfg(8'h07, 32'h0000_0104);
    wr(OFS_TRIG, 32'h0000_0001);
    hi_time(n);
    near(n, 520, 2);
    pwm_cfg(8'h3F, 32'h0000_0004);
    wr(OFS_TRIG, 32'h0000_0001);
    repeat (20) @(posedge core_clk);
    chk(pwm_out, 0);
    // A four-cycle pulse is long enough to pass the two-cycle filter
    tmic_pin_model_inst.pulse(1'b1, 4, 0);
    hi_time(n);
    near(n, 8, 2);
    pwm_cfg(8'h37, 32'h0000_0004);
    tmic_pin_model_inst.pulse(1'b1, 40, 0);
    hi_time(n);
    near(n, 8, 2);
    wr(OFS_START, 32'h0000_0000);
    // Timer B: pol bits set but ignored in timer mode
    wr(OFS_CAP_RELOAD, 32'h0000_0003);
    wr(OFS_CAP_MODE, 32'h0000_000C);
    wr(OFS_START, 32'h0000_0002);
    repeat (100) @(posedge core_clk);
    rd(OFS_STATUS, v);
    chk(v[ST_CAP_TIMER], 1);
    rd(OFS_CAP_ICR, v);
    chk(v[3], 1);
    wr(OFS_CAP_ICR, 32'h0000_0000);
    wr(OFS_CAP_MODE, 32'h0000_00C1);
    rd(OFS_STATUS, v);
    repeat (100) @(posedge core_clk);
    rd(OFS_STATUS, v);
    chk(v[ST_CAP_TIMER], 0);
    for (int p = 0; p < 3; p++) begin
      wr(OFS_CAP_MODE, {24'h00_0000, 2'h3, 2'h0, p[1:0], 2'h1});
      rd(OFS_STATUS, v);
      repeat (8) tmic_pin_model_inst.pulse(1'b0, 6, 6);
      rd(OFS_STATUS, v);
      chk(v[ST_CAP_TIMER], 1);
    end
    for (int p = 0; p < 3; p++) begin
      wr(OFS_START, 32'h0000_0000);
      wr(OFS_CAP_MODE, {28'h000_0000, p[1:0], 2'h2});
      wr(OFS_START, 32'h0000_0002);
      repeat (2) tmic_pin_model_inst.pulse(1'b0, 20, 40);
      rd(OFS_CAP_VALUE, v);
      near(v, (p == 2) ? 10 : 30, 2);
      rd(OFS_STATUS, v);
      chk(v[ST_MEASURE], 1);
    end
    wr(OFS_START, 32'h0000_0000);
    wr(OFS_MASK, 32'h0000_0001);
    pwm_cfg(8'h27, 32'h0000_0004);
    wr(OFS_TRIG, 32'h0000_0001);
    repeat (600) @(posedge core_clk);
    chk(irq, 1);
    rd(OFS_PWM_ICR, v);
    chk(v[3], 1);
    wr(OFS_START, 32'h0000_0000);
    rd(OFS_STATUS, v);
    chk(v[ST_PWM], 1);
    repeat (3) @(posedge core_clk);
    chk(irq, 0);
    wrap_up();
  end
endmodule : tb_timer_mode_and_irq_control

// ---- bench/tmic_pin_model.sv ----
// Pin-side model driving the trigger and measured input pins
module tmic_pin_model (
  input wire logic core_clk,
  output logic trig_pin,
  output logic meas_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    trig_pin = 1'b0;
    meas_pin = 1'b0;
  end
  // Pins idle low; pulses are whole clock cycles
  task automatic pulse(input bit sel, input int hi, input int lo);
    @(posedge core_clk);
    if (sel) begin
      trig_pin <= 1'b1;
    end else begin
      meas_pin <= 1'b1;
    end
    repeat (hi) @(posedge core_clk);
    trig_pin <= 1'b0;
    meas_pin <= 1'b0;
    repeat (lo) @(posedge core_clk);
  endtask : pulse
endmodule : tmic_pin_model

// ---- verilog/tmic_pkg.sv ----
// Shared constants and types for the timer mode and interrupt control block
package tmic_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PWM_MODE = 8'h00;
  localparam logic [7:0] OFS_CAP_MODE = 8'h04;
  localparam logic [7:0] OFS_PWM_ICR = 8'h08;
  localparam logic [7:0] OFS_CAP_ICR = 8'h0C;
  localparam logic [7:0] OFS_START = 8'h10;
  localparam logic [7:0] OFS_TRIG = 8'h14;
  localparam logic [7:0] OFS_PWM_RELOAD = 8'h18;
  localparam logic [7:0] OFS_CAP_RELOAD = 8'h1C;
  localparam logic [7:0] OFS_CAP_VALUE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  // Mode encodings
  localparam logic [1:0] PWM_MODE = 2'h3;
  localparam logic [1:0] CAP_TIMER = 2'h0;
  localparam logic [1:0] CAP_EVENT = 2'h1;
  localparam logic [1:0] CAP_MEASURE = 2'h2;
  localparam logic [1:0] POL_FALL = 2'h0;
  localparam logic [1:0] POL_RISE = 2'h1;
  localparam logic [1:0] POL_BOTH = 2'h2;
  localparam logic [1:0] TRIG_FALL = 2'h2;
  localparam logic [1:0] TRIG_RISE = 2'h3;
  // Period limits of the modulator
  localparam logic [15:0] PWM_MAX16 = 16'hFFFF;
  localparam logic [15:0] PWM_MAX8 = 16'h00FF;
  // Status bit positions
  localparam int ST_PWM = 0;
  localparam int ST_CAP_TIMER = 1;
  localparam int ST_MEASURE = 2;
  localparam int EVT_W = 3;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [2:0] EVT_RST = 3'h0;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] cnt_src;
    logic width8;
    logic [1:0] trig;
    logic fixed_one;
    logic [1:0] mode;
  } tmic_pwm_mode_t;

  typedef struct packed {
    logic [1:0] cnt_src;
    logic [1:0] no_store;
    logic [1:0] pol;
    logic [1:0] mode;
  } tmic_cap_mode_t;

  typedef struct packed {
    logic req;
    logic [2:0] lvl;
  } tmic_icr_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic act;
  } tmic_aphase_t;

  typedef enum logic [1:0] {PWM_IDLE, PWM_ARMED, PWM_RUN} tmic_pwm_state_t;
endpackage : tmic_pkg

// ---- verilog/tmic_timer_ctrl.sv ----
// Timer A modulator, timer B channel, interrupt control and AHB-Lite slave
// Operation
// - Timer A modulates when mode field equals three
// - Start by software, falling or rising pin
// - Bit 5 selects 16-bit or 8-bit width
// - Count clock is oscillator over 2/16/64/512
// - Timer B: timer, event counter, measurement
// - Unused timer B bits per mode ignored
// - Event counter polarity: fall, rise, both
// - Measure fall period, rise period, width
// - Timer B bits 5:4 not stored
// - Three-bit priority level, zero disables forwarding but not irq
// - Bit 3 is read-write request flag
// - Bits 3:0 reset zero, upper unstored
// - Timer A counts only while start set
//
// The AHB-Lite slave port and the address map are this design's own decisions.
module tmic_timer_ctrl (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pwm_timer_input_pin,
  input wire logic capture_input_pin,
  output logic pwm_out,
  output logic irq,
  output logic pwm_irq_fwd,
  output logic [2:0] pwm_irq_lvl,
  output logic cap_irq_fwd,
  output logic [2:0] cap_irq_lvl
);
  import tmic_pkg::*;

  // Prescaler taps, one-cycle enables
  logic [8:0] div_cnt;
  logic [8:0] next_div_cnt;
  logic clk_div_two, clk_div_sixteen, clk_div_sixtyfour, clk_div_fivetwelve;
  logic [3:0] div_tick;
  always_comb next_div_cnt = div_cnt + 9'h001;
  always_ff @(posedge core_clk) begin
    if (!rst_n) div_cnt <= 9'h000;
    else div_cnt <= next_div_cnt;
  end
  assign clk_div_two = div_cnt[0];
  assign clk_div_sixteen = &div_cnt[3:0];
  assign clk_div_sixtyfour = &div_cnt[5:0];
  assign clk_div_fivetwelve = &div_cnt[8:0];
  assign div_tick = {clk_div_fivetwelve, clk_div_sixtyfour,
                     clk_div_sixteen, clk_div_two};

  // Pin synchronisers; level accepted once stages two and three agree
  logic [1:0] pin_raw, pin_filt, pin_prev, pin_rise, pin_fall;
  assign pin_raw = {capture_input_pin, pwm_timer_input_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [2:0] stage;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          stage <= 3'h0;
          pin_filt[gi] <= 1'b0;
          pin_prev[gi] <= 1'b0;
        end else begin
          stage <= {stage[1:0], pin_raw[gi]};
          if (stage[1] == stage[2]) pin_filt[gi] <= stage[2];
          pin_prev[gi] <= pin_filt[gi];
        end
      end
      assign pin_rise[gi] = pin_filt[gi] & ~pin_prev[gi];
      assign pin_fall[gi] = ~pin_filt[gi] & pin_prev[gi];
    end
  endgenerate

  // Register state
  tmic_pwm_mode_t pwm_mode, next_pwm_mode;
  tmic_cap_mode_t cap_mode, next_cap_mode;
  tmic_icr_t pwm_icr, next_pwm_icr, cap_icr, next_cap_icr;
  tmic_aphase_t aph, next_aph;
  logic [1:0] start, next_start;
  logic soft_trig, next_soft_trig;
  logic [15:0] pwm_reload, next_pwm_reload, cap_reload, next_cap_reload;
  logic [EVT_W-1:0] status, next_status, mask, next_mask;
  logic [31:0] next_hrdata;
  logic next_irq, next_pwm_fwd, next_cap_fwd;
  logic [2:0] next_pwm_lvl, next_cap_lvl;
  logic [EVT_W-1:0] events;
  logic [15:0] cap_value;
  logic addr_ok, wr_now;
  logic [31:0] rd_val;

  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_now = aph.act & aph.wr;

  always_comb begin
    case (haddr[7:0])
      OFS_PWM_MODE: rd_val = {24'h0, pwm_mode};
      // Bits 5:4 have no storage and read zero
      OFS_CAP_MODE: rd_val = {24'h0, cap_mode.cnt_src, 2'h0,
                              cap_mode.pol, cap_mode.mode};
      OFS_PWM_ICR: rd_val = {28'h0, pwm_icr};
      OFS_CAP_ICR: rd_val = {28'h0, cap_icr};
      OFS_START: rd_val = {30'h0, start};
      OFS_PWM_RELOAD: rd_val = {16'h0, pwm_reload};
      OFS_CAP_RELOAD: rd_val = {16'h0, cap_reload};
      OFS_CAP_VALUE: rd_val = {16'h0, cap_value};
      OFS_STATUS: rd_val = {29'h0, status};
      OFS_MASK: rd_val = {29'h0, mask};
      default: rd_val = DATA_RST;
    endcase
  end

  always_comb begin
    next_aph.act = addr_ok & (hsize == 3'h2);
    next_aph.wr = hwrite;
    next_aph.addr = haddr[7:0];
    next_hrdata = (addr_ok & ~hwrite) ? rd_val : DATA_RST;
    {next_pwm_mode, next_cap_mode} = {pwm_mode, cap_mode};
    {next_pwm_icr, next_cap_icr} = {pwm_icr, cap_icr};
    {next_start, next_soft_trig} = {start, 1'b0};
    {next_pwm_reload, next_cap_reload} = {pwm_reload, cap_reload};
    {next_mask, next_status} = {mask, status};
    // Read of status clears it in the address phase
    if (addr_ok & ~hwrite & (haddr[7:0] == OFS_STATUS)) next_status = '0;
    if (wr_now) begin
      case (aph.addr)
        OFS_PWM_MODE: next_pwm_mode = hwdata[7:0];
        OFS_CAP_MODE: next_cap_mode = {hwdata[7:6], 2'h0, hwdata[3:0]};
        OFS_PWM_ICR: next_pwm_icr = hwdata[3:0];
        OFS_CAP_ICR: next_cap_icr = hwdata[3:0];
        OFS_START: next_start = hwdata[1:0];
        OFS_TRIG: next_soft_trig = hwdata[0];
        OFS_PWM_RELOAD: next_pwm_reload = hwdata[15:0];
        OFS_CAP_RELOAD: next_cap_reload = hwdata[15:0];
        OFS_MASK: next_mask = hwdata[EVT_W-1:0];
        default: ;
      endcase
    end
    // Hardware set wins over a clearing status read or request-flag write
    next_status = next_status | events;
    if (events[ST_PWM]) next_pwm_icr.req = 1'b1;
    if (events[ST_CAP_TIMER] | events[ST_MEASURE]) next_cap_icr.req = 1'b1;
    next_irq = |(status & mask);
    next_pwm_fwd = pwm_icr.req & (pwm_icr.lvl != 3'h0);
    next_cap_fwd = cap_icr.req & (cap_icr.lvl != 3'h0);
    next_pwm_lvl = next_pwm_fwd ? pwm_icr.lvl : 3'h0;
    next_cap_lvl = next_cap_fwd ? cap_icr.lvl : 3'h0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aph <= '0;
      {hrdata, hreadyout, hresp} <= {DATA_RST, 1'b1, 1'b0};
      {pwm_mode, cap_mode} <= {MODE_RST, MODE_RST};
      {pwm_icr, cap_icr} <= '0;
      {start, soft_trig} <= '0;
      {pwm_reload, cap_reload} <= {CNT_RST, CNT_RST};
      {status, mask} <= {EVT_RST, EVT_RST};
      {irq, pwm_irq_fwd, cap_irq_fwd} <= '0;
      {pwm_irq_lvl, cap_irq_lvl} <= '0;
    end else begin
      aph <= next_aph;
      {hrdata, hreadyout, hresp} <= {next_hrdata, 1'b1, 1'b0};
      {pwm_mode, cap_mode} <= {next_pwm_mode, next_cap_mode};
      {pwm_icr, cap_icr} <= {next_pwm_icr, next_cap_icr};
      {start, soft_trig} <= {next_start, next_soft_trig};
      {pwm_reload, cap_reload} <= {next_pwm_reload, next_cap_reload};
      {status, mask} <= {next_status, next_mask};
      {irq, pwm_irq_fwd, cap_irq_fwd} <=
        {next_irq, next_pwm_fwd, next_cap_fwd};
      {pwm_irq_lvl, cap_irq_lvl} <= {next_pwm_lvl, next_cap_lvl};
    end
  end

  // Timer A modulator
  tmic_pwm_state_t pwm_state, next_pwm_state;
  logic [15:0] pwm_cnt, next_pwm_cnt, pwm_top;
  logic next_pwm_out, pwm_tick, pwm_trig, pwm_ok, pwm_evt;
  assign pwm_tick = div_tick[pwm_mode.cnt_src];
  assign pwm_ok = (pwm_mode.mode == PWM_MODE) & start[0];
  assign pwm_top = pwm_mode.width8 ? PWM_MAX8 : PWM_MAX16;
  always_comb begin
    case (pwm_mode.trig)
      TRIG_FALL: pwm_trig = pin_fall[0];
      TRIG_RISE: pwm_trig = pin_rise[0];
      default: pwm_trig = soft_trig;
    endcase
  end
  always_comb begin
    next_pwm_state = pwm_state;
    next_pwm_cnt = pwm_cnt;
    pwm_evt = 1'b0;
    case (pwm_state)
      PWM_IDLE: begin
        next_pwm_cnt = CNT_RST;
        if (pwm_ok) next_pwm_state = PWM_ARMED;
      end
      PWM_ARMED: begin
        if (pwm_trig) next_pwm_state = PWM_RUN;
      end
      PWM_RUN: begin
        if (pwm_tick) begin
          if (pwm_cnt >= pwm_top) begin
            next_pwm_cnt = CNT_RST;
            pwm_evt = 1'b1;
          end else begin
            next_pwm_cnt = pwm_cnt + 16'h0001;
          end
        end
      end
      default: next_pwm_state = PWM_IDLE;
    endcase
    // Stopping or leaving the mode drops straight to idle
    if (!pwm_ok) next_pwm_state = PWM_IDLE;
    next_pwm_out = (next_pwm_state == PWM_RUN) &&
                   (next_pwm_cnt < (pwm_mode.width8 ?
                     {8'h00, pwm_reload[7:0]} : pwm_reload));
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pwm_state <= PWM_IDLE;
      {pwm_cnt, pwm_out} <= {CNT_RST, 1'b0};
    end else begin
      pwm_state <= next_pwm_state;
      {pwm_cnt, pwm_out} <= {next_pwm_cnt, next_pwm_out};
    end
  end

  // Timer B: timer, event counter or measurement
  logic [15:0] cap_cnt, next_cap_cnt, next_cap_value;
  logic cap_tick, cap_edge, meas_edge, cap_tmr_evt, meas_evt;
  assign cap_tick = div_tick[cap_mode.cnt_src];
  always_comb begin
    case (cap_mode.pol)
      POL_FALL: cap_edge = pin_fall[1];
      POL_RISE: cap_edge = pin_rise[1];
      POL_BOTH: cap_edge = pin_rise[1] | pin_fall[1];
      default: cap_edge = 1'b0;
    endcase
  end
  assign meas_edge = cap_edge & start[1] & (cap_mode.mode == CAP_MEASURE);
  always_comb begin
    next_cap_cnt = cap_cnt;
    next_cap_value = cap_value;
    cap_tmr_evt = 1'b0;
    meas_evt = 1'b0;
    if (start[1]) begin
      case (cap_mode.mode)
        // Polarity bits play no part in timer mode, only in event and measure modes
        CAP_TIMER, CAP_EVENT: begin
          if ((cap_mode.mode == CAP_TIMER) ? cap_tick : cap_edge) begin
            if (cap_cnt == CNT_RST) begin
              next_cap_cnt = cap_reload;
              cap_tmr_evt = 1'b1;
            end else begin
              next_cap_cnt = cap_cnt - 16'h0001;
            end
          end
        end
        CAP_MEASURE: begin
          if (meas_edge) begin
            next_cap_value = cap_cnt;
            next_cap_cnt = CNT_RST;
            meas_evt = 1'b1;
          end else if (cap_tick && cap_cnt != PWM_MAX16) begin
            next_cap_cnt = cap_cnt + 16'h0001;
          end
        end
        default: ;
      endcase
    end
  end
  assign events = {meas_evt, cap_tmr_evt, pwm_evt};
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      {cap_cnt, cap_value} <= {CNT_RST, CNT_RST};
    end else begin
      {cap_cnt, cap_value} <= {next_cap_cnt, next_cap_value};
    end
  end

  // Checks
  logic [2:0] cap_lvl_now;
  logic icr_read;
  assign cap_lvl_now = cap_icr.lvl;
  assign icr_read = addr_ok & ~hwrite &
    ((haddr[7:0] == OFS_PWM_ICR) | (haddr[7:0] == OFS_CAP_ICR));
  sequence s_armed_soft;
    pwm_state == PWM_ARMED && pwm_mode.trig[1] == 1'b0 && soft_trig;
  endsequence
  sequence s_armed_fall;
    pwm_state == PWM_ARMED && pwm_mode.trig == TRIG_FALL && pin_fall[0];
  endsequence
  chk_pwm_out_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwm_out |-> $past(pwm_ok)) else $error("pwm high without mode");
  chk_pwm_stop: assert property (@(posedge core_clk) disable iff (!rst_n)
    !start[0] |=> pwm_state == PWM_IDLE ##1 !pwm_out)
    else $error("pwm kept running");
  chk_soft_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_armed_soft ##0 pwm_ok |=> pwm_state == PWM_RUN)
    else $error("soft trigger missed");
  chk_fall_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    s_armed_fall ##0 pwm_ok |=> pwm_state == PWM_RUN)
    else $error("falling trigger missed");
  chk_width_eight: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwm_state == PWM_RUN && pwm_mode.width8 |-> pwm_cnt[15:8] == 8'h00)
    else $error("8-bit count overran");
  chk_req_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwm_evt |=> pwm_icr.req) else $error("request not set");
  chk_fwd_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    cap_icr.req && cap_lvl_now != 3'h0 |=>
    cap_irq_fwd && cap_irq_lvl == $past(cap_lvl_now))
    else $error("level not forwarded");
  chk_lvl_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    pwm_icr.lvl == 3'h0 |=> !pwm_irq_fwd)
    else $error("forward at level zero");
  chk_meas_capture: assert property (@(posedge core_clk) disable iff (!rst_n)
    meas_edge |=> cap_value == $past(cap_cnt) && cap_cnt == CNT_RST)
    else $error("measure not captured");
  chk_icr_upper: assert property (@(posedge core_clk) disable iff (!rst_n)
    icr_read |=> hrdata[31:4] == 28'h0)
    else $error("upper bits not zero");
  chk_evt_polarity: assert property (@(posedge core_clk) disable iff (!rst_n)
    start[1] && cap_mode.mode == CAP_EVENT && cap_mode.pol == POL_FALL &&
    !pin_fall[1] |=> cap_cnt == $past(cap_cnt))
    else $error("wrong edge counted");
endmodule : tmic_timer_ctrl
